// ==== core/sent_share_addr.sv ====
`timescale 1ns/100ps
module sent_share_addr
    import sent_share_pkg::*;
(
    input wire logic clk,                    // 250 MHz clock
    input wire logic sys_rst,                // synchronous reset
    input wire logic line_in,                // shared line level
    input wire logic [DATA_W-1:0] mag_data,  // live magnetic data
    input wire logic contention,             // collision seen by frame tx
    input wire logic selftest_active,        // self-test running
    input wire logic manchester_takeover,    // line taken by access code
    input wire logic [7:0] reg_addr,         // register byte address
    input wire logic [31:0] reg_wdata,       // register write data
    input wire logic reg_wr,                 // write strobe
    input wire logic reg_rd,                 // read strobe
    output logic [31:0] reg_rdata,           // read data, one cycle later
    output logic frame_req,                  // pulse: start a frame
    output logic [DATA_W-1:0] frame_data,    // payload for that frame
    output logic selftest_start,             // pulse: begin self-test
    output logic drive_permit                // frame tx may drive the line
);

    cfg_t cfg;
    logic link_off_reg;
    link_state_t state;
    logic [9:0] tick_div;
    logic tick_en;
    logic [2:0] line_pipe;
    logic [6:0] low_ticks;
    logic [9:0] high_ticks;
    logic [1:0] slot;
    logic id_wait;
    func_t id_func;
    logic [1:0] id_count;
    logic id_over;
    logic [DATA_W-1:0] held;
    logic held_valid;
    logic [2:0] flush_cnt;
    logic por_pending;

    logic line_now, line_rise, line_fall, listen, seq;
    func_t fn;
    logic fn_event, fn_is_addr, seq_addr_evt, id_resolve, hit;
    func_t hit_func;
    logic capture, reply, diag_go, sync_evt, idle_evt;
    logic link_off, contention_off, shutdown, discard, leave_offline;
    // filtered line; stage 0 feeds only stage 1
    assign line_now = line_pipe[1];
    assign line_rise = line_pipe[1] && !line_pipe[2];
    assign line_fall = !line_pipe[1] && line_pipe[2];
    assign listen = (state != ST_OFFLINE);
    assign seq = cfg.sequential_shared_mode;
    assign link_off = link_off_reg || manchester_takeover;
    always_ff @(posedge clk) begin
        if (sys_rst || tick_div == TICK_LAST) begin
            tick_div <= 10'h000;
        end else begin
            tick_div <= tick_div + 10'h001;
        end
    end
    assign tick_en = (tick_div == TICK_LAST);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            line_pipe <= 3'h7;
        end else begin
            line_pipe <= {line_pipe[1:0], line_in};
        end
    end
    // pulse width and idle length, both in ticks
    always_ff @(posedge clk) begin
        if (sys_rst || line_fall) begin
            low_ticks <= 7'h00;
        end else if (!line_now && tick_en && low_ticks != LOW_SAT) begin
            low_ticks <= low_ticks + 7'h01;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst || line_rise) begin
            high_ticks <= 10'h000;
        end else if (line_now && tick_en && high_ticks != HIGH_SAT) begin
            high_ticks <= high_ticks + 10'h001;
        end
    end
    always_comb begin
        fn = FN_NONE;
        if (low_ticks >= OUT_MIN && low_ticks <= OUT_MAX) begin
            fn = FN_OUTPUT;
        end
        if (low_ticks >= SMP_MIN && low_ticks <= SMP_MAX) begin
            fn = FN_SAMPLE;
        end
        if (low_ticks >= DIAG_MIN && low_ticks <= DIAG_MAX) begin
            fn = FN_DIAG;
        end
        if (low_ticks >= SYNC_MIN && low_ticks <= SYNC_MAX) begin
            fn = FN_SYNC;
        end
    end
    assign fn_is_addr = (fn == FN_OUTPUT)
        || (fn == FN_SAMPLE && cfg.sample_pulse_addresses)
        || (fn == FN_DIAG && cfg.diag_pulse_addresses);
    // while an id is being counted, low pulses are increments
    assign fn_event = listen && line_rise && fn != FN_NONE
        && !(!seq && id_wait);
    // addressing pulses only count once aligned
    assign seq_addr_evt = seq && fn_event && fn_is_addr
        && state == ST_ONLINE;
    assign id_resolve = !seq && id_wait && state == ST_ONLINE
        && line_now && tick_en && high_ticks == ID_END_TICKS - 10'd1;
    always_comb begin
        hit = 1'b0;
        hit_func = FN_NONE;
        if (seq_addr_evt && slot == cfg.sensor_id) begin
            hit = 1'b1;
            hit_func = fn;
        end else if (id_resolve && !id_over
                     && id_count == cfg.sensor_id) begin
            hit = 1'b1;
            hit_func = id_func;
        end
    end
    // both options off means no capture path
    assign capture = fn_event
        && ((fn == FN_SAMPLE && !cfg.skip_broadcast_capture)
        || (seq && fn == FN_OUTPUT && cfg.hold_on_first_slot
        && state == ST_ONLINE && slot == 2'd0));
    // output or addressing sample draws a frame
    assign reply = hit && (hit_func == FN_OUTPUT || hit_func == FN_SAMPLE);
    assign diag_go = cfg.selftest_permit
        && ((fn_event && fn == FN_DIAG && !cfg.diag_pulse_addresses)
        || (hit && hit_func == FN_DIAG));
    assign sync_evt = seq && fn_event && fn == FN_SYNC;
    assign idle_evt = seq && cfg.idle_resync && listen && line_now
        && tick_en && high_ticks == IDLE_SYNC_TICKS;
    // contention matters only in sequential mode
    assign contention_off = seq && contention && state == ST_ONLINE;
    assign shutdown = link_off || selftest_active || diag_go
        || contention_off;
    assign discard = link_off || diag_go || selftest_active;
    assign leave_offline = state == ST_OFFLINE && !shutdown
        && flush_cnt == FLUSH_CYCLES && line_now;
    // addressed mode id collection
    always_ff @(posedge clk) begin
        if (sys_rst || shutdown || seq) begin
            id_wait <= 1'b0;
            id_func <= FN_NONE;
            id_count <= 2'd0;
            id_over <= 1'b0;
        end else if (id_resolve) begin
            id_wait <= 1'b0;
        end else if (listen && line_rise && id_wait) begin
            // more than three increments is no valid id
            if (id_count == 2'd3) begin
                id_over <= 1'b1;
            end else begin
                id_count <= id_count + 2'd1;
            end
        end else if (fn_event && fn_is_addr) begin
            id_wait <= 1'b1;
            id_func <= fn;
            id_count <= 2'd0;
            id_over <= 1'b0;
        end
    end
    // held flag, capture wins over discard
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            held <= '0;
            held_valid <= 1'b0;
        end else if (capture) begin
            held <= mag_data;
            held_valid <= 1'b1;
        end else if (discard) begin
            held_valid <= 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            frame_req <= 1'b0;
            frame_data <= '0;
        end else begin
            frame_req <= reply;
            if (reply) begin
                frame_data <= (held_valid && !capture) ? held : mag_data;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            selftest_start <= 1'b0;
        end else begin
            selftest_start <= diag_go;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slot <= 2'd0;
        end else if (sync_evt || idle_evt) begin
            slot <= 2'd0;
        end else if (leave_offline && seq) begin
            slot <= 2'd0;
        end else if (seq_addr_evt) begin
            slot <= (slot == cfg.max_sensor) ? 2'd0 : slot + 2'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || state != ST_OFFLINE || shutdown) begin
            flush_cnt <= 3'd0;
        end else if (flush_cnt != FLUSH_CYCLES) begin
            flush_cnt <= flush_cnt + 3'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            por_pending <= 1'b1;
        end else if (leave_offline) begin
            por_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= ST_OFFLINE;
        end else begin
            case (state)
                ST_OFFLINE: begin
                    if (leave_offline) begin
                        if (!seq) begin
                            state <= ST_ONLINE;
                        end else if (por_pending
                                     && !cfg.hold_offline_after_power) begin
                            state <= ST_ONLINE;
                        end else begin
                            state <= ST_SLOT_ALIGN;
                        end
                    end
                end
                ST_SLOT_ALIGN: begin
                    if (shutdown) begin
                        state <= ST_OFFLINE;
                    end else if (sync_evt || idle_evt) begin
                        state <= ST_ONLINE;
                    end
                end
                ST_ONLINE: begin
                    if (shutdown) begin
                        state <= ST_OFFLINE;
                    end
                end
                default: begin
                    state <= ST_OFFLINE;
                end
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            drive_permit <= 1'b0;
        end else begin
            drive_permit <= (state == ST_ONLINE) && !shutdown;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg <= cfg_t'(CFG_RESET);
            link_off_reg <= 1'b0;
        end else if (reg_wr && reg_addr == ADDR_CFG) begin
            cfg <= cfg_t'(reg_wdata[CFG_W-1:0]);
        end else if (reg_wr && reg_addr == ADDR_CTRL) begin
            link_off_reg <= reg_wdata[CTRL_LINK_OFF];
        end
    end
    // unmapped addresses read as zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= 32'h0000_0000;
            case (reg_addr)
                ADDR_CFG: reg_rdata[CFG_W-1:0] <= cfg;
                ADDR_CTRL: reg_rdata[CTRL_LINK_OFF] <= link_off_reg;
                ADDR_STATUS: begin
                    reg_rdata[STAT_STATE_LSB +: 2] <= state;
                    reg_rdata[STAT_SLOT_LSB +: 2] <= slot;
                    reg_rdata[STAT_HELD_VALID] <= held_valid;
                    reg_rdata[STAT_ID_LSB +: 2] <= id_count;
                    reg_rdata[STAT_POR_PEND] <= por_pending;
                end
                ADDR_HELD: reg_rdata[DATA_W-1:0] <= held;
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_sync_seen;
        (sync_evt || idle_evt) && !shutdown;
    endsequence

    sequence s_now_online;
        state == ST_ONLINE && slot == 2'd0;
    endsequence

    a_offline_no_drive: assert property (
        state != ST_ONLINE |=> !drive_permit)
        else $error("drive permitted while not online");
    a_capture_holds: assert property (
        capture |=> held_valid && held == $past(mag_data))
        else $error("capture did not hold live data");
    a_no_capture_cfg: assert property (
        cfg.skip_broadcast_capture && !cfg.hold_on_first_slot |-> !capture)
        else $error("capture although both options off");
    a_reply_held: assert property (
        reply && held_valid && !capture
        |=> frame_req && frame_data == $past(held))
        else $error("poll did not return held data");
    a_diag_silent: assert property (
        fn_event && fn == FN_DIAG |=> !frame_req)
        else $error("frame after diagnostic pulse");
    a_sync_slot_zero: assert property (
        s_sync_seen |=> s_now_online)
        else $error("sync did not align slot zero");
    a_addr_direct: assert property (
        leave_offline && !seq |=> state == ST_ONLINE)
        else $error("addressed mode did not go online");
    a_align_ignores: assert property (
        state == ST_SLOT_ALIGN |-> !hit)
        else $error("reply while aligning slots");
    a_contention_off: assert property (
        contention_off |=> state == ST_OFFLINE ##1 !drive_permit)
        else $error("contention did not take sensor offline");
    a_discard_held: assert property (
        link_off && !capture |=> !held_valid)
        else $error("held data kept with link disabled");
    a_diag_start: assert property (
        diag_go |=> selftest_start && state == ST_OFFLINE)
        else $error("diagnostic did not start self-test");

endmodule

// ==== core/sent_share_pkg.sv ====
package sent_share_pkg;

    // link timing, in ticks of the sensor oscillator
    localparam int CLK_MHZ = 250;
    localparam int TICK_NS = 3000;
    localparam int TICK_CYCLES = (TICK_NS * CLK_MHZ) / 1000;
    localparam logic [9:0] TICK_LAST = 10'(TICK_CYCLES - 1);

    localparam logic [6:0] OUT_MIN = 7'd15;
    localparam logic [6:0] OUT_MAX = 7'd19;
    localparam logic [6:0] SMP_MIN = 7'd31;
    localparam logic [6:0] SMP_MAX = 7'd39;
    localparam logic [6:0] DIAG_MIN = 7'd56;
    localparam logic [6:0] DIAG_MAX = 7'd70;
    localparam logic [6:0] SYNC_MIN = 7'd93;
    localparam logic [6:0] SYNC_MAX = 7'd115;
    localparam logic [6:0] LOW_SAT = 7'h7f;
    localparam logic [9:0] ID_END_TICKS = 10'd18;
    localparam logic [9:0] IDLE_SYNC_TICKS = 10'd510;
    localparam logic [9:0] HIGH_SAT = 10'h3ff;

    // clean cycles seen before leaving offline
    localparam logic [2:0] FLUSH_CYCLES = 3'd4;

    // register map, byte addresses
    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_HELD = 8'h0c;

    localparam int DATA_W = 16;
    localparam int CTRL_LINK_OFF = 0;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_SLOT_LSB = 4;
    localparam int STAT_HELD_VALID = 8;
    localparam int STAT_ID_LSB = 12;
    localparam int STAT_POR_PEND = 16;

    typedef struct packed {
        logic sequential_shared_mode;
        logic hold_on_first_slot;
        logic skip_broadcast_capture;
        logic sample_pulse_addresses;
        logic diag_pulse_addresses;
        logic selftest_permit;
        logic idle_resync;
        logic hold_offline_after_power;
        logic [1:0] sensor_id;
        logic [1:0] max_sensor;
    } cfg_t;

    localparam int CFG_W = $bits(cfg_t);
    localparam logic [11:0] CFG_RESET = 12'h800;

    typedef enum logic [1:0] {
        ST_OFFLINE = 2'b00,
        ST_SLOT_ALIGN = 2'b01,
        ST_ONLINE = 2'b11
    } link_state_t;

    typedef enum logic [2:0] {
        FN_NONE = 3'h0,
        FN_OUTPUT = 3'h1,
        FN_SAMPLE = 3'h2,
        FN_DIAG = 3'h3,
        FN_SYNC = 3'h4
    } func_t;

endpackage

// ==== tb/sent_host_model.sv ====
`timescale 1ns/100ps
// host side of the shared line: open drain, pulled high when released
module sent_host_model
    import sent_share_pkg::*;
(
    input wire logic clk,              // bench clock
    input wire logic go,               // start one low pulse
    input wire logic [7:0] low_ticks,  // pulse width in ticks
    output logic line,                 // shared line level
    output logic busy                  // pulse or trailing idle running
);
    // idle kept short so polls stay far below the idle resync count
    localparam int GAP_TICKS = 2;

    initial begin
        line = 1'b1;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (go) begin
                busy <= 1'b1;
                line <= 1'b0;
                repeat (int'(low_ticks) * TICK_CYCLES) @(posedge clk);
                line <= 1'b1;
                repeat (GAP_TICKS * TICK_CYCLES) @(posedge clk);
                busy <= 1'b0;
            end
        end
    end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/100ps
module tb
    import sent_share_pkg::*;
;
    // four polls, one sample pulse and one addressed id wait fit under this
    localparam int CEIL = 96000;

    logic clk, sys_rst, line_in, contention, manchester_takeover;
    logic selftest_active;
    logic [DATA_W-1:0] mag_data, frame_data, last_data;
    logic [7:0] reg_addr, low_ticks;
    logic [31:0] reg_wdata, reg_rdata, rd;
    logic reg_wr, reg_rd, frame_req, selftest_start, drive_permit;
    logic go, busy;
    int n_fail, samples_checked, cycles, n_frames, f0;

    sent_share_addr u_dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .line_in(line_in),
        .mag_data(mag_data),
        .contention(contention),
        .selftest_active(selftest_active),
        .manchester_takeover(manchester_takeover),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .frame_req(frame_req),
        .frame_data(frame_data),
        .selftest_start(selftest_start),
        .drive_permit(drive_permit)
    );

    sent_host_model u_host (
        .clk(clk),
        .go(go),
        .low_ticks(low_ticks),
        .line(line_in),
        .busy(busy)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (frame_req === 1'b1) begin
            n_frames++;
            last_data = frame_data;
        end
        if (cycles == CEIL) begin
            n_fail++;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask

    // one host pulse plus its idle tail; returns with the line high
    task automatic send_pulse(input logic [7:0] t);
        f0 = n_frames;
        @(posedge clk);
        go <= 1'b1;
        low_ticks <= t;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        while (busy) @(posedge clk);
    endtask

    task automatic test_regs;
        reg_read(ADDR_CFG, rd);
        check(rd, 32'h800);
        reg_read(8'h10, rd);
        check(rd, 32'h0);
        reg_write(ADDR_CFG, 32'h803);
        reg_read(ADDR_CFG, rd);
        check(rd, 32'h803);
        reg_write(ADDR_CFG, 32'h800);
        reg_write(ADDR_HELD, 32'hffff);
        reg_read(ADDR_HELD, rd);
        check(rd, 32'h0);
        reg_read(ADDR_STATUS, rd);
        check(32'(rd[1:0]), 32'(ST_ONLINE));
        check(32'(rd[5:4]), 32'h0);
        check(32'(drive_permit), 32'h1);
    endtask

    task automatic test_fresh;
        mag_data <= 16'h1234;
        send_pulse(8'd16);
        check(32'(n_frames - f0), 32'h1);
        check(32'(last_data), 32'h1234);
        reg_read(ADDR_STATUS, rd);
        check(32'(rd[5:4]), 32'h0);
    endtask

    task automatic test_hold;
        mag_data <= 16'h5a5a;
        send_pulse(8'd32);
        check(32'(n_frames - f0), 32'h0);
        reg_read(ADDR_STATUS, rd);
        check(32'(rd[8]), 32'h1);
        reg_read(ADDR_HELD, rd);
        check(rd, 32'h5a5a);
        mag_data <= 16'h0f0f;
        send_pulse(8'd16);
        check(32'(n_frames - f0), 32'h1);
        check(32'(last_data), 32'h5a5a);
        mag_data <= 16'hc3c3;
        send_pulse(8'd16);
        check(32'(n_frames - f0), 32'h1);
        check(32'(last_data), 32'h5a5a);
    endtask

    // addressed poll of id 0 with no increments
    task automatic test_addr;
        // sample addressing off, as on every bus sensor
        reg_write(ADDR_CFG, 32'h000);
        mag_data <= 16'h7e7e;
        // no increments, line left high afterwards
        send_pulse(8'd16);
        check(32'(n_frames - f0), 32'h0);
        repeat (17 * TICK_CYCLES) @(posedge clk);
        check(32'(n_frames - f0), 32'h1);
        check(32'(last_data), 32'h5a5a);
        // back to sequential for the bus
        reg_write(ADDR_CFG, 32'h800);
    endtask

    task automatic test_drop;
        @(posedge clk);
        contention <= 1'b1;
        @(posedge clk);
        contention <= 1'b0;
        #1 check(32'(drive_permit), 32'h0);
        repeat (16) @(posedge clk);
        reg_read(ADDR_STATUS, rd);
        // power-up already consumed, so sequential waits for alignment
        check(32'(rd[1:0]), 32'(ST_SLOT_ALIGN));
        check(32'(rd[8]), 32'h1);
        check(32'(drive_permit), 32'h0);
        @(posedge clk);
        manchester_takeover <= 1'b1;
        @(posedge clk);
        manchester_takeover <= 1'b0;
        repeat (4) @(posedge clk);
        reg_read(ADDR_STATUS, rd);
        check(32'(rd[8]), 32'h0);
        @(posedge clk);
        selftest_active <= 1'b1;
        repeat (8) @(posedge clk);
        reg_read(ADDR_STATUS, rd);
        check(32'(rd[1:0]), 32'(ST_OFFLINE));
        check(32'(drive_permit), 32'h0);
        @(posedge clk);
        selftest_active <= 1'b0;
    endtask

    initial begin
        n_fail = 0;
        samples_checked = 0;
        cycles = 0;
        n_frames = 0;
        f0 = 0;
        sys_rst = 1'b1;
        contention = 1'b0;
        manchester_takeover = 1'b0;
        selftest_active = 1'b0;
        mag_data = 16'h0;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        go = 1'b0;
        low_ticks = 8'h0;
        repeat (16) @(posedge clk);
        #1 check(32'(drive_permit), 32'h0);
        @(posedge clk);
        sys_rst <= 1'b0;
        repeat (20) @(posedge clk);
        test_regs();
        test_fresh();
        test_hold();
        test_addr();
        test_drop();
        report_and_stop();
    end
endmodule
